//--- bench/scp_serial_control_port_sva.sv
// Pin-level assertions for the serial control port
`timescale 1ns/100ps
module scp_serial_control_port_sva (
   input wire logic        ref_clk,
   input wire logic        srst,
   input wire logic        spiModeIn,
   input wire logic        spiCsN,
   input wire logic        sdioOeN,
   input wire logic        readbackOeN,
   input wire logic        i2cSdaOut,
   input wire logic [12:0] cfgAddr,
   input wire logic [7:0]  cfgData,
   input wire logic        updateStrobe,
   input wire logic        xferActive
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // Counts cover the two-stage pin synchroniser
   sequence s_csIdle; spiCsN [*4]; endsequence
   sequence s_csLow; (spiModeIn && !spiCsN) [*5]; endsequence
   property p_idleFloat; s_csIdle |=> sdioOeN && readbackOeN; endproperty
   a_idleFloat: assert property (p_idleFloat) else $error("pin driven");
   property p_oneDriver; sdioOeN || readbackOeN; endproperty
   a_oneDriver: assert property (p_oneDriver) else $error("two drivers");
   property p_cycleStart; s_csLow |=> xferActive; endproperty
   a_cycleStart: assert property (p_cycleStart) else $error("no cycle");
   property p_resetQuiet; disable iff (1'h0)
      srst |=> sdioOeN && readbackOeN && !xferActive && !updateStrobe;
   endproperty
   a_resetQuiet: assert property (p_resetQuiet) else $error("reset");
   property p_strobePulse; updateStrobe |=> !updateStrobe; endproperty
   a_strobePulse: assert property (p_strobePulse) else $error("strb");
   property p_strobeInXfer; updateStrobe |-> $past(xferActive); endproperty
   a_strobeInXfer: assert property (p_strobeInXfer) else $error("st");
   property p_highAddr; cfgAddr > 13'h0B03 |=> cfgData == 8'h00; endproperty
   a_highAddr: assert property (p_highAddr) else $error("unmapped");
   property p_sdaOpenDrain; !i2cSdaOut; endproperty
   a_sdaOpenDrain: assert property (p_sdaOpenDrain) else $error("sda");
endmodule // scp_serial_control_port_sva
bind scp_serial_control_port scp_serial_control_port_sva u_sva (
   .ref_clk(ref_clk), .srst(srst), .spiModeIn(spiModeIn), .spiCsN(spiCsN),
   .sdioOeN(sdioOeN), .readbackOeN(readbackOeN), .i2cSdaOut(i2cSdaOut),
   .cfgAddr(cfgAddr), .cfgData(cfgData), .updateStrobe(updateStrobe),
   .xferActive(xferActive));

//--- bench/scp_serial_control_port_tb.sv
// Self-checking bench for the serial control port over SPI and two-wire
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin \
   err_count++; $display("Error %s expected %h seen %h", nm, e, g); \
   end end
module scp_serial_control_port_tb;
   typedef struct {logic [39:0] b; int n; int brk; logic [23:0] m, e;}
      scp_row_t;
   logic        ref_clk = 1'h0;
   logic        srst = 1'h1;
   logic        spiMode = 1'h1, scl = 1'h1, sda = 1'h1;
   // Address 1011000, write, then a released ack slot
   logic [8:0]  i2cBits = 9'h161;
   logic [12:0] cfgAddr = 13'h0012;
   logic [39:0] rd;
   logic [7:0]  cfgData;
   logic        spiSclk, spiCsN, sdioDrv, sdioIn, sdioOut, sdioOeN;
   logic        readbackOut, readbackOeN, i2cSdaOut, i2cSdaOeN;
   logic        updateStrobe, xferActive;
   int          err_count = 0, n_compared = 0, cyc = 0, nUpd = 0;
   // Instruction and data bits, bit count, stall point, mask, readback
   scp_row_t rows[12] = '{
      '{{16'h4012, 24'hAA55C3}, 40, 24, 24'h0, 24'h0},
      '{{16'hC012, 24'h0}, 40, 16, 24'hFFFFFF, 24'hAA55C3},
      '{{16'h0020, 8'h77, 16'h0}, 20, 99, 24'h0, 24'h0},
      '{{16'h8020, 24'h0}, 24, 99, 24'hFF, 24'h00},
      '{{16'h1F00, 8'hFF, 16'h0}, 24, 99, 24'h0, 24'h0},
      '{{16'h9F00, 24'h0}, 24, 99, 24'hFF, 24'h00},
      '{{16'h6001, 24'h5A9901}, 40, 99, 24'h0, 24'h0},
      '{{16'h8011, 24'h0}, 24, 99, 24'hFF, 24'h55},
      '{{16'h0004, 8'h01, 16'h0}, 24, 99, 24'h0, 24'h0},
      '{{16'h0232, 8'h01, 16'h0}, 24, 99, 24'h0, 24'h0},
      '{{16'h0012, 8'h3C, 16'h0}, 24, 99, 24'h0, 24'h0},
      '{{16'hE012, 24'h0}, 40, 99, 24'hFFFFFF, 24'hAA55C3}};
   scp_serial_control_port uut (
      .ref_clk(ref_clk), .srst(srst), .spiModeIn(spiMode),
      .i2cAddrLow(3'h0), .spiSclk(spiSclk), .spiCsN(spiCsN),
      .sdioIn(sdioIn), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
      .readbackOut(readbackOut), .readbackOeN(readbackOeN),
      .i2cScl(scl), .i2cSdaIn(sda & (i2cSdaOeN | i2cSdaOut)),
      .i2cSdaOut(i2cSdaOut), .i2cSdaOeN(i2cSdaOeN), .cfgAddr(cfgAddr),
      .cfgData(cfgData), .updateStrobe(updateStrobe),
      .xferActive(xferActive));
   scp_spi_master m (
      .ref_clk(ref_clk), .sdioOut(sdioOut), .sdioOeN(sdioOeN),
      .readbackOut(readbackOut), .readbackOeN(readbackOeN),
      .spiSclk(spiSclk), .spiCsN(spiCsN), .sdioDrv(sdioDrv));
   assign sdioIn = sdioOeN ? sdioDrv : sdioOut;
   task automatic final_report();
      $display("Compared %0d, mismatches %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always #50 ref_clk = ~ref_clk;
   // Ceiling well above the roughly 3200 cycles the run needs
   always @(posedge ref_clk) begin
      cyc++;
      nUpd += int'(updateStrobe);
      if (cyc == 20000) begin
         err_count++;
         final_report();
      end
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      srst <= 1'h0;
      repeat (4) @(posedge ref_clk);
      #10;
      `CHK("sdioOeN", 1'h1, sdioOeN)
      `CHK("readbackOeN", 1'h1, readbackOeN)
      foreach (rows[i]) begin
         m.xfer(rows[i].b, rows[i].n, rows[i].brk, rd);
         `CHK("readback", rows[i].e, rd[23:0] & rows[i].m)
      end
      `CHK("active", 8'hAA, cfgData)
      @(posedge ref_clk);
      cfgAddr <= 13'h1500;
      repeat (3) @(posedge ref_clk);
      #10;
      `CHK("unmapped", 8'h00, cfgData)
      `CHK("updates", 32'h2, nUpd)
      @(posedge ref_clk);
      spiMode <= 1'h0;
      repeat (8) @(posedge ref_clk);
      sda <= 1'h0;
      for (int i = 0; i < 9; i++) begin
         repeat (4) @(posedge ref_clk);
         scl <= 1'h0;
         sda <= i2cBits[8 - i];
         repeat (4) @(posedge ref_clk);
         scl <= 1'h1;
      end
      repeat (2) @(posedge ref_clk);
      #10;
      `CHK("ack", 1'h0, i2cSdaOeN)
      `CHK("busy", 1'h1, xferActive)
      final_report();
   end
endmodule // scp_serial_control_port_tb

//--- bench/scp_spi_master.sv
// Behavioural SPI controller driving the serial pins
`timescale 1ns/100ps
module scp_spi_master (
   input  wire logic ref_clk,
   input  wire logic sdioOut,
   input  wire logic sdioOeN,
   input  wire logic readbackOut,
   input  wire logic readbackOeN,
   output logic      spiSclk = 1'h0,
   output logic      spiCsN  = 1'h1,
   output logic      sdioDrv = 1'h0
);
   // word first, stalls on byte edges
   task automatic xfer(input logic [39:0] bits, input int n,
                       input int brk, output logic [39:0] rd);
      rd = '0;
      @(posedge ref_clk);
      spiCsN <= 1'h0;
      for (int i = 0; i < n; i++) begin
         if (i == brk) begin
            spiCsN <= 1'h1;
            repeat (24) @(posedge ref_clk);
            spiCsN <= 1'h0;
            repeat (4) @(posedge ref_clk);
         end
         spiSclk <= 1'h0;
         sdioDrv <= bits[39-i];
         repeat (4) @(posedge ref_clk);
         spiSclk <= 1'h1;
         repeat (3) @(posedge ref_clk);
         @(negedge ref_clk);
         // Undriven line shows the inverse of its last level
         rd = {rd[38:0], !readbackOeN ? readbackOut :
               !sdioOeN ? sdioOut : ~rd[0]};
         @(posedge ref_clk);
      end
      spiSclk <= 1'h0;
      repeat (4) @(posedge ref_clk);
      spiCsN <= 1'h1;
      sdioDrv <= ~sdioDrv;
      repeat (16) @(posedge ref_clk);
   endtask
endmodule // scp_spi_master

//--- verilog/scp_pkg.sv
// Constants, field positions and state types of the serial control port
package scp_pkg;

   // ---------------------------------------------------------------
   // Register map
   // ---------------------------------------------------------------
   localparam int          REG_COUNT     = 32'hB04;
   localparam logic [15:0] REG_LAST      = 16'h0B03;
   localparam logic [12:0] REG_FIRST     = 13'h0000;
   localparam logic [12:0] REG_UPDATE    = 13'h0232;
   localparam logic [11:0] REG_PORTCFG   = 12'h000;
   localparam logic [11:0] REG_READSEL   = 12'h004;
   localparam logic [7:0]  PORTCFG_RESET = 8'h18;
   localparam logic [7:0]  REG_RESET     = 8'h00;
   localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

   // Bit positions inside the port, readback and update registers
   localparam int CFG_UNI_HI  = 7;
   localparam int CFG_UNI_LO  = 0;
   localparam int CFG_LSB     = 1;
   localparam int READSEL_BIT = 0;
   localparam int UPDATE_BIT  = 0;

   // ---------------------------------------------------------------
   // Instruction word
   // ---------------------------------------------------------------
   localparam int         INS_RW        = 15;
   localparam int         INS_LEN_HI    = 14;
   localparam int         INS_LEN_LO    = 13;
   localparam int         INS_ADDR_HI   = 12;
   localparam logic [1:0] LEN_ONE       = 2'h0;
   localparam logic [1:0] LEN_TWO       = 2'h1;
   localparam logic [1:0] LEN_THREE     = 2'h2;
   localparam logic [1:0] LEN_STREAM    = 2'h3;
   localparam logic [3:0] INS_LAST_BIT  = 4'hF;
   localparam logic [2:0] BYTE_LAST_BIT = 3'h7;

   // ---------------------------------------------------------------
   // Two-wire framing
   // ---------------------------------------------------------------
   localparam logic [3:0] I2C_ADDR_HI  = 4'hB;
   localparam logic [3:0] I2C_BIT_LAST = 4'h7;
   localparam logic [3:0] I2C_ACK_CNT  = 4'h8;
   localparam logic [3:0] I2C_ACK_END  = 4'h9;

   // Pin synchroniser: mode, addr[2:0], sclk, csN, sdio, scl, sda
   localparam int         SYNC_W     = 9;
   localparam logic [8:0] SYNC_RESET = 9'h00B;

   typedef enum logic [2:0] {
      SPI_INSTR = 3'b001,
      SPI_DATA  = 3'b010,
      SPI_DONE  = 3'b100
   } scp_spi_state_t;

   typedef enum logic [5:0] {
      I2C_IDLE = 6'b000001,
      I2C_DEV  = 6'b000010,
      I2C_AHI  = 6'b000100,
      I2C_ALO  = 6'b001000,
      I2C_WR   = 6'b010000,
      I2C_RD   = 6'b100000
   } scp_i2c_state_t;

endpackage

//--- verilog/scp_serial_control_port.sv
// Serial control port: SPI slave, two-wire slave and register buffer
// Operation
// - Two-wire send format only loads the internal register pointer.
// - Two-wire write: two address bytes high first, then acked data bytes.
// - Two-wire read without address returns data from current pointer onward.
// - SPI samples write bits on SCLK rise, changes read bits on fall.
// - After reset one bidirectional data pin carries input and readback.
// - Config bits 7 and 0 both set: readback on separate output pin.
// - Chip select high floats both data outputs; low starts a cycle.
// - Only the 16-bit instruction format is accepted.
// - First 16 rising edges shift in direction, length and start address.
// - Short transfers may stall chip select high on byte boundaries only.
// - While stalled the state machine keeps progress and resumes later.
// - Chip select rising mid-byte resets the port, discarding partial data.
// - Streaming moves the address each byte until the update register or a chip select rise.
// - Two-bit length code selects one, two, three bytes or streaming.
// - Multibyte access visits every address, reserved ones included.
// - Writes land in a buffer; self-clearing update bit copies to active.
// - Read shifts out N bytes, or streams until the update register or a chip select rise.
// - Readback source, buffer or active, chosen by a readback bit.
// - Decoded register space spans 0x000 to 0xB03.
// - Top bit direction, next two length code, low 13 bits address.
// - MSB-first decrements the address per byte, LSB-first increments.
`timescale 1ns/100ps
module scp_serial_control_port (
   input  wire logic        ref_clk,
   input  wire logic        srst,
   input  wire logic        spiModeIn,
   input  wire logic [2:0]  i2cAddrLow,
   input  wire logic        spiSclk,
   input  wire logic        spiCsN,
   input  wire logic        sdioIn,
   output logic             sdioOut,
   output logic             sdioOeN,
   output logic             readbackOut,
   output logic             readbackOeN,
   input  wire logic        i2cScl,
   input  wire logic        i2cSdaIn,
   output logic             i2cSdaOut,
   output logic             i2cSdaOeN,
   input  wire logic [12:0] cfgAddr,
   output logic      [7:0]  cfgData,
   output logic             updateStrobe,
   output logic             xferActive
);

   // ---------------------------------------------------------------
   // Pin synchronisation and edge detection
   // ---------------------------------------------------------------
   logic [scp_pkg::SYNC_W-1:0] pinRaw;
   logic [scp_pkg::SYNC_W-1:0] pinSync;
   logic                       spiSel;
   logic [2:0]                 addrLowS;
   logic                       sclkS;
   logic                       csS;
   logic                       sdioS;
   logic                       sclS;
   logic                       sdaS;
   logic                       sclkPrev_q;
   logic                       csPrev_q;
   logic                       sclPrev_q;
   logic                       sdaPrev_q;

   assign pinRaw = {spiModeIn, i2cAddrLow, spiSclk, spiCsN, sdioIn,
                    i2cScl, i2cSdaIn};

   scp_sync #(
      .WIDTH     (scp_pkg::SYNC_W),
      .RESET_VAL (scp_pkg::SYNC_RESET)
   ) u_sync (
      .ref_clk (ref_clk),
      .srst    (srst),
      .pinIn   (pinRaw),
      .pinSync (pinSync)
   );

   assign {spiSel, addrLowS, sclkS, csS, sdioS, sclS, sdaS} = pinSync;

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sclkPrev_q <= 1'h0;
         csPrev_q   <= 1'h1;
         sclPrev_q  <= 1'h1;
         sdaPrev_q  <= 1'h1;
      end else begin
         sclkPrev_q <= sclkS;
         csPrev_q   <= csS;
         sclPrev_q  <= sclS;
         sdaPrev_q  <= sdaS;
      end
   end

   logic sclkRise;
   logic sclkFall;
   logic csRise;
   logic sclRise;
   logic sclFall;

   assign sclkRise = sclkS & ~sclkPrev_q;
   assign sclkFall = ~sclkS & sclkPrev_q;
   assign csRise   = csS & ~csPrev_q;
   assign sclRise  = sclS & ~sclPrev_q;
   assign sclFall  = ~sclS & sclPrev_q;

   // ---------------------------------------------------------------
   // Register storage: buffer and active copies
   // ---------------------------------------------------------------
   logic [7:0]  bufMem [scp_pkg::REG_COUNT];
   logic [7:0]  actMem [scp_pkg::REG_COUNT];
   logic        lsbFirst;
   logic        uniDir;
   logic        readActive;
   logic        wrEn;
   logic [11:0] wrAddr;
   logic [7:0]  wrData;

   // Port format bits act at once, without an update
   assign lsbFirst   = bufMem[scp_pkg::REG_PORTCFG][scp_pkg::CFG_LSB];
   assign uniDir     = bufMem[scp_pkg::REG_PORTCFG][scp_pkg::CFG_UNI_HI] &
                       bufMem[scp_pkg::REG_PORTCFG][scp_pkg::CFG_UNI_LO];
   assign readActive = bufMem[scp_pkg::REG_READSEL][scp_pkg::READSEL_BIT];

   // readback source; outside the map reads zero
   function automatic logic [7:0] rdByte(input logic [15:0] a);
      if (a > scp_pkg::REG_LAST) begin
         return scp_pkg::RD_UNMAPPED;
      end
      return readActive ? actMem[a[11:0]] : bufMem[a[11:0]];
   endfunction

   // buffered writes, update copies every byte at once
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
            bufMem[i] <= scp_pkg::REG_RESET;
            actMem[i] <= scp_pkg::REG_RESET;
         end
         bufMem[scp_pkg::REG_PORTCFG] <= scp_pkg::PORTCFG_RESET;
         actMem[scp_pkg::REG_PORTCFG] <= scp_pkg::PORTCFG_RESET;
         updateStrobe                 <= 1'h0;
      end else begin
         updateStrobe <= 1'h0;
         if (wrEn) begin
            if ({1'h0, wrAddr} == scp_pkg::REG_UPDATE) begin
               // Update bit is never stored, so it reads back cleared
               if (wrData[scp_pkg::UPDATE_BIT]) begin
                  for (int i = 0; i < scp_pkg::REG_COUNT; i++) begin
                     actMem[i] <= bufMem[i];
                  end
                  updateStrobe <= 1'h1;
               end
            end else begin
               bufMem[wrAddr] <= wrData;
            end
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         cfgData <= scp_pkg::RD_UNMAPPED;
      end else if ({3'h0, cfgAddr} > scp_pkg::REG_LAST) begin
         cfgData <= scp_pkg::RD_UNMAPPED;
      end else begin
         cfgData <= actMem[cfgAddr[11:0]];
      end
   end

   // ---------------------------------------------------------------
   // SPI engine
   // ---------------------------------------------------------------
   scp_pkg::scp_spi_state_t spiState_q;
   logic [3:0]              spiBitCnt_q;
   logic [15:0]             spiShift_q;
   logic                    spiRead_q;
   logic [1:0]              spiLen_q;
   logic [12:0]             spiAddr_q;
   logic [1:0]              spiByteCnt_q;
   logic [15:0]             spiWordIn;
   logic [7:0]              spiByteIn;
   logic [12:0]             spiAddrNext;
   logic                    spiLast;
   logic                    spiStep;
   logic                    spiAbort;
   logic                    spiInstrDone;
   logic                    spiByteDone;
   logic                    spiWrHit;

   // bits taken on rising SCLK while selected
   assign spiStep   = spiSel & sclkRise & ~csS;
   assign spiWordIn = lsbFirst ? {sdioS, spiShift_q[15:1]}
                               : {spiShift_q[14:0], sdioS};
   assign spiByteIn = lsbFirst ? spiWordIn[15:8] : spiWordIn[7:0];

   assign spiAddrNext = lsbFirst ? spiAddr_q + 13'h1 :
                        (spiAddr_q == scp_pkg::REG_FIRST) ?
                        scp_pkg::REG_UPDATE : spiAddr_q - 13'h1;

   // length code; streaming ends at the update register
   assign spiLast = (spiLen_q == scp_pkg::LEN_STREAM) ?
                    (spiAddr_q == scp_pkg::REG_UPDATE) :
                    (spiByteCnt_q == spiLen_q);

   // mid-byte rise resets; rise after last byte ends
   assign spiAbort = ~spiSel | (csRise &
                     ((spiBitCnt_q[2:0] != 3'h0) ||
                      (spiState_q == scp_pkg::SPI_DONE) ||
                      ((spiState_q == scp_pkg::SPI_DATA) &&
                       (spiLen_q == scp_pkg::LEN_STREAM))));

   // instruction complete after 16 rising edges
   assign spiInstrDone = spiStep && (spiState_q == scp_pkg::SPI_INSTR) &&
                         (spiBitCnt_q == scp_pkg::INS_LAST_BIT);
   assign spiByteDone  = spiStep && (spiState_q == scp_pkg::SPI_DATA) &&
                         (spiBitCnt_q[2:0] == scp_pkg::BYTE_LAST_BIT);
   assign spiWrHit     = spiByteDone && !spiRead_q &&
                         ({3'h0, spiAddr_q} <= scp_pkg::REG_LAST);

   always_ff @(posedge ref_clk) begin
      if (srst || spiAbort) begin
         spiState_q   <= scp_pkg::SPI_INSTR;
         spiBitCnt_q  <= 4'h0;
         spiShift_q   <= 16'h0000;
         spiRead_q    <= 1'h0;
         spiLen_q     <= scp_pkg::LEN_ONE;
         spiAddr_q    <= scp_pkg::REG_FIRST;
         spiByteCnt_q <= 2'h0;
      end else if (spiStep) begin
         // a stall simply withholds steps; progress stays put
         unique case (spiState_q)
            scp_pkg::SPI_INSTR: begin
               spiShift_q  <= spiWordIn;
               spiBitCnt_q <= spiBitCnt_q + 4'h1;
               if (spiInstrDone) begin
                  spiState_q   <= scp_pkg::SPI_DATA;
                  spiBitCnt_q  <= 4'h0;
                  spiRead_q    <= spiWordIn[scp_pkg::INS_RW];
                  spiLen_q     <= spiWordIn[scp_pkg::INS_LEN_HI:
                                            scp_pkg::INS_LEN_LO];
                  spiAddr_q    <= spiWordIn[scp_pkg::INS_ADDR_HI:0];
                  spiByteCnt_q <= 2'h0;
               end
            end
            scp_pkg::SPI_DATA: begin
               spiShift_q  <= spiWordIn;
               spiBitCnt_q <= {1'h0, spiBitCnt_q[2:0] + 3'h1};
               if (spiByteDone) begin
                  spiAddr_q    <= spiAddrNext;
                  spiByteCnt_q <= spiByteCnt_q + 2'h1;
                  if (spiLast) begin
                     spiState_q <= scp_pkg::SPI_DONE;
                  end
               end
            end
            scp_pkg::SPI_DONE: begin
               spiBitCnt_q <= {1'h0, spiBitCnt_q[2:0] + 3'h1};
            end
         endcase
      end
   end

   // ---------------------------------------------------------------
   // SPI readback shifter and pin drive
   // ---------------------------------------------------------------
   logic [7:0] spiTx_q;
   logic       spiDrv_q;

   // next byte loaded on the rising edge that closes a byte
   always_ff @(posedge ref_clk) begin
      if (srst || spiAbort) begin
         spiTx_q     <= scp_pkg::RD_UNMAPPED;
         spiDrv_q    <= 1'h0;
         sdioOut     <= 1'h0;
         readbackOut <= 1'h0;
      end else if (spiInstrDone) begin
         spiTx_q <= rdByte({3'h0, spiWordIn[scp_pkg::INS_ADDR_HI:0]});
      end else if (spiByteDone) begin
         spiTx_q <= rdByte({3'h0, spiAddrNext});
         if (spiLast) begin
            spiDrv_q <= 1'h0;
         end
      end else if (spiSel && sclkFall && !csS && spiRead_q &&
                   (spiState_q == scp_pkg::SPI_DATA)) begin
         // read bits change on falling SCLK
         sdioOut     <= lsbFirst ? spiTx_q[0] : spiTx_q[7];
         readbackOut <= lsbFirst ? spiTx_q[0] : spiTx_q[7];
         spiTx_q     <= lsbFirst ? {1'h0, spiTx_q[7:1]}
                                 : {spiTx_q[6:0], 1'h0};
         spiDrv_q    <= 1'h1;
      end
   end

   // both outputs float while chip select is high
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         sdioOeN     <= 1'h1;
         readbackOeN <= 1'h1;
      end else begin
         // shared pin by default; separate pin when set
         sdioOeN     <= ~(spiDrv_q & ~csS & spiSel & ~uniDir);
         readbackOeN <= ~(spiDrv_q & ~csS & spiSel & uniDir);
      end
   end

   // ---------------------------------------------------------------
   // Two-wire engine
   // ---------------------------------------------------------------
   scp_pkg::scp_i2c_state_t i2cState_q;
   logic [3:0]              i2cCnt_q;
   logic [7:0]              i2cShift_q;
   logic [15:0]             i2cPtr_q;
   logic [7:0]              i2cTx_q;
   logic                    i2cAckPend_q;
   logic [7:0]              i2cByteIn;
   logic                    i2cStart;
   logic                    i2cStop;
   logic                    i2cActive;
   logic                    i2cWrHit;

   assign i2cByteIn = {i2cShift_q[6:0], sdaS};
   assign i2cStart  = ~spiSel & sclS & sclPrev_q & sdaPrev_q & ~sdaS;
   assign i2cStop   = ~spiSel & sclS & sclPrev_q & ~sdaPrev_q & sdaS;
   assign i2cActive = ~spiSel & (i2cState_q != scp_pkg::I2C_IDLE);
   // data bytes stored at the pointer
   assign i2cWrHit  = i2cActive && sclRise && !i2cStart && !i2cStop &&
                      (i2cState_q == scp_pkg::I2C_WR) &&
                      (i2cCnt_q == scp_pkg::I2C_BIT_LAST) &&
                      (i2cPtr_q <= scp_pkg::REG_LAST);

   always_ff @(posedge ref_clk) begin
      if (srst || spiSel) begin
         i2cState_q   <= scp_pkg::I2C_IDLE;
         i2cCnt_q     <= 4'h0;
         i2cShift_q   <= 8'h00;
         i2cPtr_q     <= 16'h0000;
         i2cTx_q      <= scp_pkg::RD_UNMAPPED;
         i2cAckPend_q <= 1'h0;
         i2cSdaOeN    <= 1'h1;
         i2cSdaOut    <= 1'h0;
      end else if (i2cStart) begin
         // Repeated start keeps the pointer for a random read
         i2cState_q   <= scp_pkg::I2C_DEV;
         i2cCnt_q     <= 4'h0;
         i2cAckPend_q <= 1'h0;
         i2cSdaOeN    <= 1'h1;
      end else if (i2cStop) begin
         i2cState_q   <= scp_pkg::I2C_IDLE;
         i2cCnt_q     <= 4'h0;
         i2cAckPend_q <= 1'h0;
         i2cSdaOeN    <= 1'h1;
      end else if (i2cActive && sclRise) begin
         if (i2cCnt_q < scp_pkg::I2C_ACK_CNT) begin
            i2cShift_q <= i2cByteIn;
            i2cCnt_q   <= i2cCnt_q + 4'h1;
            if (i2cCnt_q == scp_pkg::I2C_BIT_LAST) begin
               unique case (i2cState_q)
                  scp_pkg::I2C_DEV: begin
                     if (i2cByteIn[7:1] == {scp_pkg::I2C_ADDR_HI,
                                            addrLowS}) begin
                        i2cAckPend_q <= 1'h1;
                        // read starts at the current pointer
                        if (i2cByteIn[0]) begin
                           i2cState_q <= scp_pkg::I2C_RD;
                           i2cTx_q    <= rdByte(i2cPtr_q);
                        end else begin
                           i2cState_q <= scp_pkg::I2C_AHI;
                        end
                     end else begin
                        i2cState_q <= scp_pkg::I2C_IDLE;
                     end
                  end
                  // address bytes only move the pointer
                  scp_pkg::I2C_AHI: begin
                     i2cPtr_q[15:8] <= i2cByteIn;
                     i2cAckPend_q   <= 1'h1;
                     i2cState_q     <= scp_pkg::I2C_ALO;
                  end
                  scp_pkg::I2C_ALO: begin
                     i2cPtr_q[7:0] <= i2cByteIn;
                     i2cAckPend_q  <= 1'h1;
                     i2cState_q    <= scp_pkg::I2C_WR;
                  end
                  scp_pkg::I2C_WR: begin
                     i2cPtr_q     <= i2cPtr_q + 16'h0001;
                     i2cAckPend_q <= 1'h1;
                  end
                  scp_pkg::I2C_RD: begin
                  end
                  scp_pkg::I2C_IDLE: begin
                  end
               endcase
            end
         end else if (i2cCnt_q == scp_pkg::I2C_ACK_CNT) begin
            i2cCnt_q <= scp_pkg::I2C_ACK_END;
            // Master acknowledge slot: a high level ends the read
            if ((i2cState_q == scp_pkg::I2C_RD) && !i2cAckPend_q) begin
               i2cPtr_q <= i2cPtr_q + 16'h0001;
               i2cTx_q  <= rdByte(i2cPtr_q + 16'h0001);
               if (sdaS) begin
                  i2cState_q <= scp_pkg::I2C_IDLE;
               end
            end
         end
      end else if (i2cActive && sclFall) begin
         if (i2cCnt_q == scp_pkg::I2C_ACK_CNT) begin
            i2cSdaOeN <= ~i2cAckPend_q;
         end else if (i2cCnt_q == scp_pkg::I2C_ACK_END) begin
            i2cAckPend_q <= 1'h0;
            i2cCnt_q     <= 4'h0;
            if (i2cState_q == scp_pkg::I2C_RD) begin
               i2cSdaOeN <= i2cTx_q[7];
               i2cTx_q   <= {i2cTx_q[6:0], 1'h0};
            end else begin
               i2cSdaOeN <= 1'h1;
            end
         end else if ((i2cState_q == scp_pkg::I2C_RD) &&
                      (i2cCnt_q != 4'h0)) begin
            i2cSdaOeN <= i2cTx_q[7];
            i2cTx_q   <= {i2cTx_q[6:0], 1'h0};
         end
      end
   end

   // ---------------------------------------------------------------
   // Shared buffer write port and status
   // ---------------------------------------------------------------
   always_comb begin
      wrEn   = 1'h0;
      wrAddr = spiAddr_q[11:0];
      wrData = spiByteIn;
      if (spiWrHit) begin
         wrEn = 1'h1;
      end else if (i2cWrHit) begin
         wrEn   = 1'h1;
         wrAddr = i2cPtr_q[11:0];
         wrData = i2cByteIn;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         xferActive <= 1'h0;
      end else begin
         xferActive <= spiSel ? ~csS : i2cActive;
      end
   end

endmodule // scp_serial_control_port

//--- verilog/scp_sync.sv
// Two-stage synchroniser for pins arriving from outside ref_clk
`timescale 1ns/100ps
module scp_sync #(
   parameter int               WIDTH     = 1,
   parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
   input  wire logic             ref_clk,
   input  wire logic             srst,
   input  wire logic [WIDTH-1:0] pinIn,
   output logic      [WIDTH-1:0] pinSync
);

   logic [WIDTH-1:0] meta_q;

   // First stage feeds only the second stage
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         meta_q  <= RESET_VAL;
         pinSync <= RESET_VAL;
      end else begin
         meta_q  <= pinIn;
         pinSync <= meta_q;
      end
   end

endmodule // scp_sync
